// File: partner_caps_pkg.sv
// Register map, field layout and reset values of the partner capability bank.
// Assumes a byte-addressed Avalon-MM port, one 32-bit word for each register.
package partner_caps_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CAPS = 8'h35;
  localparam logic [7:0] IDX_SPARE_A = 8'h36;
  localparam logic [7:0] IDX_DESER = 8'h37;
  localparam logic [7:0] IDX_SPARE_B = 8'h38;
  localparam logic [7:0] IDX_TARGET0 = 8'h39;
  // Field positions
  localparam int CAPS_HOLD_BIT = 7;
  localparam int CAPS_PARTNER_MULTIPORT_FLAG_BIT = 4;
  localparam int CAPS_PORT_LSB = 0;
  localparam int PORT_W = 4;
  localparam int ADDR7_LSB = 1;
  localparam int DESER_HOLD_BIT = 0;
  // Reset values
  localparam logic [7:0] CAPS_RST = 8'h00;
  localparam logic [7:0] SPARE_RST = 8'h00;
  localparam logic [6:0] DESER_ADDR_RST = 7'h3D;
  localparam logic [7:0] TARGET_RST = 8'h00;
  localparam logic [7:0] UPPER_RST = 8'h00;
  // Byte address from index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr
endpackage : partner_caps_pkg

// File: partner_caps_target_remap_regs.sv
// Partner capability, partner address and remote target registers with alias-0 remap.
// Assumes control-channel and I2C request inputs come from logic on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module partner_caps_target_remap_regs
  import partner_caps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bc_link_detected,
  input wire logic cc_update,
  input wire logic cc_multiport,
  input wire logic [PORT_W-1:0] cc_port_num,
  input wire logic [6:0] cc_deser_addr,
  input wire logic [6:0] alias0_addr,
  input wire logic i2c_req_valid,
  input wire logic [6:0] i2c_req_addr,
  output logic fwd_valid,
  output logic [6:0] fwd_addr,
  output logic partner_multiport_flag,
  output logic [PORT_W-1:0] partner_port_num,
  output logic [6:0] partner_deser_address
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] caps_reg, caps_next;
  logic [7:0] spare_a_reg, spare_a_next;
  logic [6:0] deser_addr_reg, deser_addr_next;
  logic deser_hold_reg, deser_hold_next;
  logic [7:0] spare_b_reg, spare_b_next;
  logic [6:0] target_reg, target_next;
  logic wait_reg, wait_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic fwd_valid_reg, fwd_valid_next;
  logic [6:0] fwd_addr_reg, fwd_addr_next;

  logic req;
  logic accept;
  logic wr_lane0;
  logic caps_load;
  logic addr_load;
  logic alias_hit;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == byte_addr(idx));
  endfunction : hit

  assign req = avs_read | avs_write;
  // The answer lands one cycle after the request is seen; waitrequest idles high
  assign accept = req & ~wait_reg;
  assign wr_lane0 = accept & avs_write & avs_byteenable[0];
  assign caps_load = cc_update & bc_link_detected & ~caps_reg[CAPS_HOLD_BIT];
  assign addr_load = cc_update & bc_link_detected & ~deser_hold_reg;
  // An alias of zero counts as unconfigured
  assign alias_hit = (alias0_addr != 7'h00) & (i2c_req_addr == alias0_addr);

  // ----------------------------------------
  // Bus slave and register updates
  // ----------------------------------------
  always_comb
  begin
    wait_next = ~(req & wait_reg);
    rdata_next = rdata_reg;
    caps_next = caps_reg;
    spare_a_next = spare_a_reg;
    deser_addr_next = deser_addr_reg;
    deser_hold_next = deser_hold_reg;
    spare_b_next = spare_b_reg;
    target_next = target_reg;
    if (caps_load)
    begin
      caps_next[CAPS_PARTNER_MULTIPORT_FLAG_BIT] = cc_multiport;
      caps_next[CAPS_PORT_LSB +: PORT_W] = cc_port_num;
    end
    if (addr_load)
    begin
      deser_addr_next = cc_deser_addr;
    end
    // Software writes win over a load in the same cycle
    if (wr_lane0)
    begin
      if (hit(avs_address, IDX_CAPS))
      begin
        caps_next = avs_writedata[7:0];
      end
      else if (hit(avs_address, IDX_SPARE_A))
      begin
        spare_a_next = avs_writedata[7:0];
      end
      else if (hit(avs_address, IDX_DESER))
      begin
        deser_addr_next = avs_writedata[7:ADDR7_LSB];
        deser_hold_next = avs_writedata[DESER_HOLD_BIT];
      end
      else if (hit(avs_address, IDX_SPARE_B))
      begin
        spare_b_next = avs_writedata[7:0];
      end
      else if (hit(avs_address, IDX_TARGET0))
      begin
        target_next = avs_writedata[7:ADDR7_LSB];
      end
    end
    if (req & wait_reg)
    begin
      // Unmapped addresses read as zero and ignore writes
      if (hit(avs_address, IDX_CAPS))
      begin
        rdata_next = {24'h000000, caps_reg};
      end
      else if (hit(avs_address, IDX_SPARE_A))
      begin
        rdata_next = {24'h000000, spare_a_reg};
      end
      else if (hit(avs_address, IDX_DESER))
      begin
        rdata_next = {24'h000000, deser_addr_reg, deser_hold_reg};
      end
      else if (hit(avs_address, IDX_SPARE_B))
      begin
        rdata_next = {24'h000000, spare_b_reg};
      end
      else if (hit(avs_address, IDX_TARGET0))
      begin
        rdata_next = {24'h000000, target_reg, 1'b0};
      end
      else
      begin
        rdata_next = 32'h00000000;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      caps_reg <= CAPS_RST;
      spare_a_reg <= SPARE_RST;
      deser_addr_reg <= DESER_ADDR_RST;
      deser_hold_reg <= 1'b0;
      spare_b_reg <= SPARE_RST;
      target_reg <= TARGET_RST[7:1];
    end
    else
    begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      caps_reg <= caps_next;
      spare_a_reg <= spare_a_next;
      deser_addr_reg <= deser_addr_next;
      deser_hold_reg <= deser_hold_next;
      spare_b_reg <= spare_b_next;
      target_reg <= target_next;
    end
  end

  // ----------------------------------------
  // Alias 0 remap toward the control channel
  // ----------------------------------------
  always_comb
  begin
    fwd_valid_next = i2c_req_valid;
    fwd_addr_next = fwd_addr_reg;
    if (i2c_req_valid)
    begin
      fwd_addr_next = alias_hit ? target_reg : i2c_req_addr;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      fwd_valid_reg <= 1'b0;
      fwd_addr_reg <= 7'h00;
    end
    else
    begin
      fwd_valid_reg <= fwd_valid_next;
      fwd_addr_reg <= fwd_addr_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign fwd_valid = fwd_valid_reg;
  assign fwd_addr = fwd_addr_reg;
  assign partner_multiport_flag = caps_reg[CAPS_PARTNER_MULTIPORT_FLAG_BIT];
  assign partner_port_num = caps_reg[CAPS_PORT_LSB +: PORT_W];
  assign partner_deser_address = deser_addr_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_read_caps;
    avs_read && wait_reg && hit(avs_address, IDX_CAPS);
  endsequence
  sequence s_answer;
    !avs_waitrequest;
  endsequence

  bus_answer_a: assert property (req && wait_reg |=> s_answer ##1 avs_waitrequest)
    else $error("waitrequest did not pulse low once");
  partner_multiport_flag_read_a: assert property (s_read_caps |=> s_answer and (avs_readdata[4] == $past(caps_reg[4])))
    else $error("multiport flag read mismatch");
  caps_load_a: assert property (caps_load && !wr_lane0 |=> partner_multiport_flag == $past(cc_multiport))
    else $error("capability auto-load missed");
  port_load_a: assert property (caps_load && !wr_lane0 |=> partner_port_num == $past(cc_port_num))
    else $error("port number auto-load missed");
  caps_hold_a: assert property (caps_reg[7] && !wr_lane0 |=> $stable(caps_reg))
    else $error("capabilities changed while held");
  addr_hold_a: assert property (deser_hold_reg && !wr_lane0 |=> $stable(partner_deser_address))
    else $error("partner address changed while held");
  addr_load_a: assert property (addr_load && !wr_lane0 |=> partner_deser_address == $past(cc_deser_addr))
    else $error("partner address auto-load missed");
  target_read_a: assert property (avs_read && wait_reg && hit(avs_address, IDX_TARGET0)
    |=> avs_readdata == {24'h000000, $past(target_reg), 1'b0})
    else $error("target read mismatch");
  remap_hit_a: assert property (i2c_req_valid && alias_hit |=> fwd_valid && fwd_addr == $past(target_reg))
    else $error("alias 0 not remapped");
  remap_miss_a: assert property (i2c_req_valid && !alias_hit |=> fwd_valid && fwd_addr == $past(i2c_req_addr))
    else $error("unmatched address altered");

endmodule : partner_caps_target_remap_regs
`default_nettype wire

// File: deser_partner_model.sv
// Remote deserializer stand-in reporting partner values over the control channel.
// Assumes one report request at a time from the bench, on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module deser_partner_model
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic link_up,
  input wire logic send,
  input wire logic [3:0] lag,
  input wire logic [11:0] report,
  output logic bc_link_detected,
  output logic cc_update,
  output logic cc_multiport,
  output logic [3:0] cc_port_num,
  output logic [6:0] cc_deser_addr
);
  logic [4:0] cnt;
  logic [11:0] held;
  always @(posedge sys_clk)
  begin
    bc_link_detected <= link_up & ~reset;
    cc_update <= cnt == 5'h01;
    if (reset || send)
    begin
      cnt <= reset ? 5'h00 : {1'b0, lag} + 5'h01;
      held <= report;
    end
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
    // Data is valid only beside the strobe, so it shows the inverse elsewhere
    {cc_multiport, cc_port_num, cc_deser_addr} <= (cnt == 5'h01) ? held : ~held;
  end
endmodule : deser_partner_model
`default_nettype wire

// File: test_partner_caps_target_remap_regs.sv
// Random bus, partner-load and remap traffic against a reference model of the bank.
// Assumes the package and the partner model.
`timescale 1ns/100ps
`default_nettype none
module test_partner_caps_target_remap_regs
  import partner_caps_pkg::*;
;
  logic sys_clk = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0, link_up = 1'b0, send = 1'b0, iv = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wd = '0, rdata;
  logic [3:0] be = 4'hF, lag = 4'h0, pn, cpn;
  logic [11:0] report = 12'h000;
  logic [6:0] alias0 = 7'h00, ia = 7'h00, fa, da, cda;
  logic mp, cu, cm, fv, bl, wt;
  logic [7:0] caps_e, deser_e, tgt_e;
  int err_count = 0, compares = 0;
  partner_caps_target_remap_regs u_partner_caps_target_remap_regs (.sys_clk(sys_clk), .reset(reset),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wt), .bc_link_detected(bl), .cc_update(cu), .cc_multiport(cm),
    .cc_port_num(cpn), .cc_deser_addr(cda), .alias0_addr(alias0), .i2c_req_valid(iv), .i2c_req_addr(ia),
    .fwd_valid(fv), .fwd_addr(fa), .partner_multiport_flag(mp), .partner_port_num(pn),
    .partner_deser_address(da));
  deser_partner_model u_deser_partner_model (.sys_clk(sys_clk), .reset(reset), .link_up(link_up),
    .send(send), .lag(lag), .report(report), .bc_link_detected(bl), .cc_update(cu), .cc_multiport(cm),
    .cc_port_num(cpn), .cc_deser_addr(cda));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic complete_run;
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_reg
  task automatic check_fwd(input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value forward expected %h seen %h", exp, got);
    end
  endtask : check_fwd
  // Alias zero is unconfigured, so nothing is remapped while it is zero
  function automatic logic [7:0] remap_exp(input logic [6:0] al, input logic [6:0] a, input logic [6:0] t);
    remap_exp = {1'b1, (al != 7'h00 && a == al) ? t : a};
  endfunction : remap_exp
  // Holds the request until waitrequest is sampled low, giving up after 20 cycles
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    addr <= {idx, 2'b00};
    wr <= w;
    rd <= ~w;
    wd <= {24'h000000, d};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wt !== 1'b0 && n < 20);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wt !== 1'b0)
    begin
      err_count++;
      complete_run;
    end
  endtask : bus
  task automatic verify;
    logic [31:0] q;
    bus(1'b0, IDX_CAPS, 8'h00, q);
    check_reg("caps", {24'h000000, caps_e}, q);
    bus(1'b0, IDX_DESER, 8'h00, q);
    check_reg("deser", {24'h000000, deser_e}, q);
    bus(1'b0, IDX_TARGET0, 8'h00, q);
    check_reg("target", {24'h000000, tgt_e}, q);
    check_reg("fields", {20'h00000, caps_e[4:0], deser_e[7:1]}, {20'h00000, mp, pn, da});
  endtask : verify
  initial
  begin
    logic [31:0] q;
    logic [11:0] r;
    logic [7:0] d;
    logic [6:0] al, a;
    logic ln, lk;
    void'($urandom(32'hFDD4));
    caps_e = 8'h00;
    deser_e = {7'h3D, 1'b0};
    tgt_e = 8'h00;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    verify;
    bus(1'b0, 8'h3A, 8'h00, q);
    check_reg("unmapped", 32'h00000000, q);
    for (int k = 0; k < 80; k++)
    begin
      d = 8'($urandom);
      ln = 1'($urandom);
      be <= {3'($urandom), ln};
      case ($urandom % 5)
        0: begin bus(1'b1, IDX_CAPS, d, q); if (ln) caps_e = d; end
        1: begin bus(1'b1, IDX_DESER, d, q); if (ln) deser_e = d; end
        2: begin bus(1'b1, IDX_TARGET0, d, q); if (ln) tgt_e = {d[7:1], 1'b0}; end
        3:
        begin
          lk = ($urandom % 4) != 0;
          r = 12'($urandom);
          @(posedge sys_clk);
          link_up <= lk;
          send <= 1'b1;
          report <= r;
          lag <= 4'($urandom);
          @(posedge sys_clk);
          send <= 1'b0;
          repeat (20) @(posedge sys_clk);
          if (lk && !caps_e[7]) caps_e[4:0] = r[11:7];
          if (lk && !deser_e[0]) deser_e[7:1] = r[6:0];
        end
        default:
        begin
          al = ($urandom % 8 == 0) ? 7'h00 : 7'($urandom % 127 + 1);
          a = ($urandom % 2) ? al : 7'($urandom);
          @(posedge sys_clk);
          alias0 <= al;
          iv <= 1'b1;
          ia <= a;
          @(posedge sys_clk);
          iv <= 1'b0;
          @(posedge sys_clk);
          check_fwd(remap_exp(al, a, tgt_e[7:1]), {fv, fa});
          @(posedge sys_clk);
          check_reg("fwd_valid", 32'h00000000, {31'h00000000, fv});
        end
      endcase
      verify;
      if (k == 40)
      begin
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        check_reg("fwd_reset", 32'h00000000, {24'h000000, fv, fa});
        caps_e = CAPS_RST;
        deser_e = {DESER_ADDR_RST, 1'b0};
        tgt_e = TARGET_RST;
        verify;
      end
    end
    complete_run;
  end
endmodule : test_partner_caps_target_remap_regs
`default_nettype wire
